// ==== hw/mnd_pkg.sv ====
// Purpose: shared constants and types for the move/nop/option decoder
// Assumes: 12-bit instruction words, 8-bit data path
// Notes:   opcode patterns are compared after masking don't-care bits
package mnd_pkg;

    // ------------------------------------------------------------
    // widths
    // ------------------------------------------------------------
    localparam int IW_W   = 12;          // instruction word width
    localparam int DW     = 8;           // data path width
    localparam int FA_W   = 5;           // file address width
    localparam int NREG   = 32;          // registers 0..31

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int DEST_BIT = 5;         // d bit position
    localparam int FA_LSB   = 0;         // f field low bit

    // ------------------------------------------------------------
    // opcode masks and matches
    // ------------------------------------------------------------
    localparam logic [11:0] COPY_MASK  = 12'hFC0;
    localparam logic [11:0] COPY_MATCH = 12'h200;
    localparam logic [11:0] STORE_MASK = 12'hFE0;
    localparam logic [11:0] STORE_MATCH = 12'h020;
    localparam logic [11:0] LIT_MASK   = 12'hF00;
    localparam logic [11:0] LIT_MATCH  = 12'hC00;
    localparam logic [11:0] NOP_WORD   = 12'h000;
    localparam logic [11:0] OPT_WORD   = 12'h002;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [7:0] ACC_RST  = 8'h00;
    localparam logic [7:0] OPT_RST  = 8'hFF;
    localparam logic [7:0] FILE_RST = 8'h00;

    // decoded operation, one-hot
    typedef enum logic [5:0] {
        OP_NONE  = 6'h01,
        OP_COPY  = 6'h02,
        OP_STORE = 6'h04,
        OP_LIT   = 6'h08,
        OP_NOP   = 6'h10,
        OP_OPT   = 6'h20
    } mnd_op_t;

    // instruction handed in with its strobe
    typedef struct packed {
        logic        valid;              // word present this cycle
        logic [11:0] word;               // instruction word
    } mnd_instr_t;

    // architectural state seen outside
    typedef struct packed {
        logic [7:0] acc;                 // accumulator
        logic [7:0] option;              // option register
        logic       zero;                // zero flag
    } mnd_state_t;

endpackage : mnd_pkg

// ==== hw/mnd_decode.sv ====
// Purpose: decode and execute five single-cycle instructions
// Assumes: INSTR arrives on CLK from same-domain fetch logic
// Notes:   other opcodes are ignored here; ALU ops live elsewhere
module mnd_decode
(
    // clock and reset
    input  wire logic               CLK,
    input  wire logic               RST_N,
    // fetched instruction
    input  wire mnd_pkg::mnd_instr_t INSTR,
    // register file read port for observers
    input  wire logic [4:0]         DBG_ADDR,
    // architectural state
    output mnd_pkg::mnd_state_t     STATE,
    output logic [7:0]              DBG_DATA,
    output logic                    DONE
);
    import mnd_pkg::*;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    // file_next copies the whole file; only the addressed entry differs
    logic [DW-1:0]  file_reg [NREG];   // file registers
    logic [DW-1:0]  file_next [NREG];  // next file values
    logic [DW-1:0]  acc_reg, acc_next;  // accumulator
    logic [DW-1:0]  opt_reg, opt_next;  // option register
    logic           z_reg, z_next;      // zero flag
    logic [DW-1:0]  dbg_reg, dbg_next;  // observer read data
    logic           done_reg, done_next; // one-cycle completion
    mnd_op_t        op;                 // decoded operation
    logic [FA_W-1:0] fa;                // file address
    logic           dest;               // d bit
    logic [DW-1:0]  moved;              // value read from file

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    // the five patterns never overlap, so the order of tests is free;
    // a word that matches none of them leaves op at OP_NONE
    always_comb
    begin
        fa    = INSTR.word[FA_LSB +: FA_W];
        dest  = INSTR.word[DEST_BIT];
        moved = file_reg[fa];
        op    = OP_NONE;
        // a low valid means no word was fetched this cycle
        if (!INSTR.valid)
            op = OP_NONE;                            // idle cycle
        else if ((INSTR.word & COPY_MASK) == COPY_MATCH)
            op = OP_COPY;
        else if ((INSTR.word & STORE_MASK) == STORE_MATCH)
            op = OP_STORE;
        else if ((INSTR.word & LIT_MASK) == LIT_MATCH)
            op = OP_LIT;
        else if (INSTR.word == NOP_WORD)
            op = OP_NOP;
        else if (INSTR.word == OPT_WORD)
            op = OP_OPT;
    end

    // ------------------------------------------------------------
    // execute: next values
    // ------------------------------------------------------------
    // every path starts from the held values, so an ignored word
    // changes nothing; a copy with d=1 still refreshes the zero flag
    always_comb
    begin
        acc_next  = acc_reg;
        opt_next  = opt_reg;
        z_next    = z_reg;
        file_next = file_reg;
        done_next = 1'b0;
        dbg_next  = file_reg[DBG_ADDR];
        case (op)
            OP_COPY:
            begin
                if (!dest)
                    acc_next = moved;
                else
                    file_next[fa] = moved;
                z_next    = (moved == 8'h00);
                done_next = 1'b1;
            end
            OP_STORE:
            begin
                file_next[fa] = acc_reg;
                done_next     = 1'b1;
            end
            OP_LIT:
            begin
                acc_next  = INSTR.word[DW-1:0];
                done_next = 1'b1;
            end
            OP_NOP:
                done_next = 1'b1;
            OP_OPT:
            begin
                opt_next  = acc_reg;
                done_next = 1'b1;
            end
            default:
                done_next = 1'b0;                    // not ours
        endcase
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    // core registers; reset is synchronous so it needs no extra
    // synchroniser, but RST_N must be held across a full clock edge
    always_ff @(posedge CLK)
    begin
        if (!RST_N)
        begin
            acc_reg  <= ACC_RST;
            opt_reg  <= OPT_RST;
            z_reg    <= 1'b0;
            dbg_reg  <= FILE_RST;
            done_reg <= 1'b0;
        end
        else
        begin
            acc_reg  <= acc_next;
            opt_reg  <= opt_next;
            z_reg    <= z_next;
            dbg_reg  <= dbg_next;
            done_reg <= done_next;
        end
    end

    // one register per entry so reset clears the whole file;
    // 32 resettable bytes cost area, but a copy never reads junk
    genvar gi;
    generate
        for (gi = 0; gi < NREG; gi++)
        begin : g_file
            always_ff @(posedge CLK)
            begin
                if (!RST_N)
                    file_reg[gi] <= FILE_RST;
                else
                    file_reg[gi] <= file_next[gi];
            end
        end
    endgenerate

    // outputs straight from flops
    assign STATE = '{acc:    acc_reg,         // accumulator
                     option: opt_reg,         // option register
                     zero:   z_reg};          // zero flag
    assign DBG_DATA     = dbg_reg;
    assign DONE         = done_reg;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    // every check is off while reset is held
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_N);

    // checks built on the decoded operation
    a_copy_to_acc: assert property (
        op == OP_COPY && !dest |=> acc_reg == $past(moved))
        else $error("copy to accumulator wrong");
    a_copy_zero: assert property (
        op == OP_COPY |=> z_reg == ($past(moved) == 8'h00))
        else $error("zero flag wrong after copy");
    a_store_file: assert property (
        op == OP_STORE |=>
            file_reg[$past(fa)] == $past(acc_reg) && $stable(z_reg))
        else $error("store wrote the wrong value");
    a_store_acc_kept: assert property (
        op == OP_STORE |=> $stable(acc_reg) && $stable(opt_reg))
        else $error("store touched the accumulator");
    a_literal_load: assert property (
        op == OP_LIT |=> acc_reg == $past(INSTR.word[7:0]) && $stable(z_reg))
        else $error("literal load wrong");
    a_nop_still: assert property (
        op == OP_NOP |=> $stable(acc_reg) && $stable(opt_reg)
            && $stable(z_reg) && done_reg)
        else $error("no-operation changed state");
    a_option_load: assert property (
        op == OP_OPT |=> opt_reg == $past(acc_reg) && $stable(z_reg))
        else $error("option load wrong");
    a_copy_dest_file: assert property (
        op == OP_COPY && dest |=>
            $stable(acc_reg) && file_reg[$past(fa)] == $past(moved))
        else $error("copy with d=1 went astray");
    a_done_one_cycle: assert property (
        op != OP_NONE |=> done_reg)
        else $error("instruction not done in one cycle");

    // checks that decode the word themselves, apart from op
    a_copy_addr: assert property (
        INSTR.valid && (INSTR.word & 12'hFE0) == 12'h200 |=>
            acc_reg == $past(file_reg[INSTR.word[4:0]]))
        else $error("copy read the wrong register");
    a_literal_word: assert property (
        INSTR.valid && INSTR.word[11:8] == 4'hC |=>
            acc_reg == $past(INSTR.word[7:0]) && done_reg)
        else $error("literal word not loaded");
    a_option_word: assert property (
        INSTR.valid && INSTR.word == 12'h002 |=>
            opt_reg == $past(acc_reg) && done_reg)
        else $error("option word not loaded");

    // main scenarios worth seeing at least once
    c_copy_zero: cover property (op == OP_COPY ##1 z_reg);
    c_store_then_copy: cover property (op == OP_STORE ##1 op == OP_COPY);
    c_lit_then_opt: cover property (op == OP_LIT ##1 op == OP_OPT);
    c_nop: cover property (op == OP_NOP);
    c_copy_to_file: cover property (op == OP_COPY && dest ##1 !z_reg);

endmodule // mnd_decode

// ==== dv/mnd_prog_mem.sv ====
// Purpose: program memory model handing one word per cycle
// Assumes: the bench picks the word and the fetch enable
// Notes:   an idle slot shows the inverted word, never a stale one
module mnd_prog_mem
(
    // fetch control
    input  wire logic           en,
    input  wire logic [11:0]    word,
    // instruction out
    output mnd_pkg::mnd_instr_t instr
);
    timeunit 1ns;
    timeprecision 1ps;
    import mnd_pkg::*;
    // inverted when idle so a decoder that ignores valid is caught
    assign instr = en ? {1'b1, word} : {1'b0, ~word};
endmodule // mnd_prog_mem

// ==== dv/mnd_decode_test.sv ====
// Purpose: self-checking bench for the move/nop/option decoder
// Assumes: one word per cycle, results visible one edge later
// Notes:   file contents are read back through the observe port
`define CHK(n, e, g) \
    begin samples_checked++; if ((g) !== (e)) begin err_count++; \
    $display("Error %s expected %0h seen %0h", n, e, g); end end
module mnd_decode_test;
    timeunit 1ns;
    timeprecision 1ps;
    import mnd_pkg::*;
    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    logic       CLK;        // 25 MHz core clock
    logic       RST_N;      // synchronous reset, active low
    logic       en;         // fetch enable to the memory model
    logic [11:0] word;      // word offered by the memory model
    mnd_instr_t instr;      // word plus valid into the decoder
    logic [4:0] dbg_addr;   // observed file register
    mnd_state_t state;      // accumulator, option, zero
    logic [7:0] dbg_data;   // observed file value
    logic       done;       // one-cycle completion pulse
    int         err_count;
    int         samples_checked;
    mnd_prog_mem mem (.en(en), .word(word), .instr(instr));
    mnd_decode dut (.CLK(CLK), .RST_N(RST_N), .INSTR(instr),
        .DBG_ADDR(dbg_addr), .STATE(state), .DBG_DATA(dbg_data),
        .DONE(done));
    // 40 ns period
    initial CLK = 1'b0;
    always #20 CLK = ~CLK;
    // ------------------------------------------------------------
    // drivers
    // ------------------------------------------------------------
    // offer a word; returns after its result is visible
    task automatic put(input logic [11:0] w);
        word = w;
        en = 1'b1;
        @(posedge CLK);
        #1;
    endtask
    // drop valid for one cycle
    task automatic idle();
        en = 1'b0;
        @(posedge CLK);
        #1;
    endtask
    // read a file register through the registered observe port
    task automatic rd(input logic [4:0] a, input logic [7:0] e);
        dbg_addr = a;
        @(posedge CLK);
        #1;
        `CHK("file", e, dbg_data)
    endtask
    task automatic stop_test();
        $display("checks %0d errors %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0)
        begin
            $display("All checks passed");
        end
        else
        begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    // literal loads back to back, top of range
    task automatic s_literal();
        put(12'hC5A);
        `CHK("done", 1'b1, done)
        `CHK("acc", 8'h5A, state.acc)
        put(12'hCFF);
        `CHK("acc", 8'hFF, state.acc)
        idle();
        `CHK("done", 1'b0, done)
    endtask
    // store, copy both ways, option, nop, unknown word, in one run
    task automatic s_chain();
        put(12'hC3C);
        put(12'h03F);
        put(12'hC00);
        put(12'h022);
        put(12'hC55);
        put(12'h222);
        `CHK("zero", 1'b1, state.zero)
        `CHK("acc", 8'h55, state.acc)
        put(12'hC81);
        `CHK("zero", 1'b1, state.zero)
        put(12'h020);
        `CHK("zero", 1'b1, state.zero)
        `CHK("acc", 8'h81, state.acc)
        put(12'h002);
        `CHK("option", 8'h81, state.option)
        `CHK("zero", 1'b1, state.zero)
        put(12'h23F);
        `CHK("zero", 1'b0, state.zero)
        `CHK("acc", 8'h81, state.acc)
        put(12'h202);
        `CHK("acc", 8'h00, state.acc)
        `CHK("zero", 1'b1, state.zero)
        put(12'h21F);
        `CHK("acc", 8'h3C, state.acc)
        `CHK("zero", 1'b0, state.zero)
        put(12'h000);
        `CHK("done", 1'b1, done)
        `CHK("acc", 8'h3C, state.acc)
        `CHK("zero", 1'b0, state.zero)
        put(12'h001);
        `CHK("done", 1'b0, done)
        `CHK("acc", 8'h3C, state.acc)
        idle();
        rd(5'h1F, 8'h3C);
        rd(5'h00, 8'h81);
        rd(5'h02, 8'h00);
    endtask
    // mid-run reset brings back every reset value, file register 31 read back too
    task automatic s_reset();
        en = 1'b0;
        RST_N = 1'b0;
        repeat (2) @(posedge CLK);
        #1;
        RST_N = 1'b1;
        `CHK("acc", ACC_RST, state.acc)
        `CHK("option", OPT_RST, state.option)
        `CHK("zero", 1'b0, state.zero)
        `CHK("done", 1'b0, done)
        rd(5'h1F, FILE_RST);
        put(12'hC18);
        `CHK("acc", 8'h18, state.acc)
    endtask
    // ------------------------------------------------------------
    // main sequence and watchdog
    // ------------------------------------------------------------
    initial
    begin
        RST_N = 1'b0;
        en = 1'b0;
        word = 12'h000;
        dbg_addr = 5'h00;
        err_count = 0;
        samples_checked = 0;
        repeat (5) @(posedge CLK);
        #1;
        RST_N = 1'b1;
        `CHK("option", OPT_RST, state.option)
        `CHK("acc", ACC_RST, state.acc)
        s_literal();
        s_chain();
        s_reset();
        stop_test();
    end
    initial
    begin
        repeat (2000) @(posedge CLK);
        err_count++;
        stop_test();
    end
endmodule // mnd_decode_test
